/* hw/array_clock_divider.sv */
// Purpose: Counter clock enable source selection and division
// Assumes: Timer0 overflow is a same-clock pulse; pins are asynchronous
// Notes: One pulse of tick per counter clock
`timescale 1ns/1ps
module array_clock_divider #(
    parameter int DIV12 = wdt_pkg::DIV12_COUNT,
    parameter int DIV4 = wdt_pkg::DIV4_COUNT,
    parameter int EXTDIV = wdt_pkg::EXT_DIV_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic [wdt_pkg::SEL_W-1:0] select,
    input wire logic timer0_overflow,
    input wire logic eci_pin,
    input wire logic extclk_pin,
    output logic tick
);
    logic [3:0] sys_count;
    logic [2:0] ext_count;
    logic [1:0] eci_sync;
    logic [1:0] ext_sync;
    logic eci_last;
    logic ext_last;
    logic eci_fall;
    logic ext_rise;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eci_sync <= 2'b00;
            ext_sync <= 2'b00;
            eci_last <= 1'b0;
            ext_last <= 1'b0;
        end else begin
            eci_sync <= {eci_sync[0], eci_pin};
            ext_sync <= {ext_sync[0], extclk_pin};
            eci_last <= eci_sync[1];
            ext_last <= ext_sync[1];
        end
    end

    assign eci_fall = eci_last & ~eci_sync[1];
    assign ext_rise = ext_sync[1] & ~ext_last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_count <= 4'h0;
            ext_count <= 3'h0;
        end else if (clear) begin
            sys_count <= 4'h0;
            ext_count <= 3'h0;
        end else begin
            sys_count <= (sys_count == 4'(DIV12 - 1)) ? 4'h0 : sys_count + 4'h1;
            if (ext_rise) begin
                ext_count <= ext_count + 3'h1;
            end
        end
    end

    always_comb begin
        unique case (wdt_pkg::clock_sel_t'(select))
            wdt_pkg::SEL_SYS_DIV12: tick = (sys_count == 4'(DIV12 - 1));
            wdt_pkg::SEL_SYS_DIV4: tick = (sys_count[1:0] == 2'(DIV4 - 1));
            wdt_pkg::SEL_TIMER0: tick = timer0_overflow;
            wdt_pkg::SEL_EXT_EDGE: tick = eci_fall;
            wdt_pkg::SEL_SYSTEM: tick = 1'b1;
            wdt_pkg::SEL_EXTCLK_DIV8: tick = ext_rise & (ext_count == 3'(EXTDIV - 1));
            default: tick = 1'b0;
        endcase
    end

endmodule : array_clock_divider

/* hw/counter_array_watchdog.sv */
// Purpose: Watchdog on counter array module 2, with APB registers
// Assumes: cpu_idle and timer0_overflow come from logic on pclk
// Notes: watchdog_reset is a one-cycle request to the system reset logic
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module counter_array_watchdog (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic eci_pin,
    input wire logic extclk_pin,
    output logic watchdog_reset,
    output logic watchdog_active
);
    logic [7:0] array_count_low;
    logic [7:0] array_count_high;
    logic [7:0] watchdog_offset_reg;
    logic [7:0] watchdog_match_reg;
    logic counter_run;
    logic overflow_flag;
    logic idle_suspend_bit;
    logic watchdog_enable_bit;
    logic watchdog_lock_bit;
    logic [wdt_pkg::SEL_W-1:0] array_clock_select;
    logic fired_flag;
    logic soft_clear;
    logic raw_tick;
    logic suspended;
    logic step;
    logic low_wrap;
    logic timeout_hit;
    logic force_hit;
    logic fire;
    logic wr_access;
    logic rd_setup;
    logic addr_valid;
    logic wr_control;
    logic wr_mode;
    logic wr_low;
    logic wr_high;
    logic wr_offset;
    logic wr_match;
    logic wr_status;
    logic [7:0] wbyte;
    logic [7:0] next_read;
    logic count_enable;
    logic count_full;
    logic high_matches;
    logic force_write;
    logic mode_open;
    logic [7:0] control_image;
    logic [7:0] mode_image;
    logic [7:0] status_image;

    function automatic logic is_mapped(input logic [wdt_pkg::ADDR_W-1:0] a);
        is_mapped = (a == wdt_pkg::ADDR_CONTROL) || (a == wdt_pkg::ADDR_MODE) ||
                    (a == wdt_pkg::ADDR_COUNT_LOW) || (a == wdt_pkg::ADDR_COUNT_HIGH) ||
                    (a == wdt_pkg::ADDR_OFFSET) || (a == wdt_pkg::ADDR_MATCH) ||
                    (a == wdt_pkg::ADDR_STATUS);
    endfunction : is_mapped

    // Write strobe for one register of the map
    function automatic logic write_hit(
        input logic strobe,
        input logic [wdt_pkg::ADDR_W-1:0] a,
        input logic [wdt_pkg::ADDR_W-1:0] target
    );
        write_hit = strobe & (a == target);
    endfunction : write_hit

    // match byte from live high byte
    function automatic logic [7:0] restart_point(
        input logic [7:0] high,
        input logic [7:0] offset
    );
        // Wraps modulo 256, like the compare it feeds
        restart_point = high + offset;
    endfunction : restart_point

    // APB: zero-wait access phase, read data latched in setup
    assign addr_valid = is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_valid;
    assign wr_access = psel & penable & pwrite & addr_valid;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wbyte = pwdata[7:0];

    assign wr_control = write_hit(wr_access, paddr, wdt_pkg::ADDR_CONTROL);
    assign wr_mode = write_hit(wr_access, paddr, wdt_pkg::ADDR_MODE);
    assign wr_low = write_hit(wr_access, paddr, wdt_pkg::ADDR_COUNT_LOW);
    assign wr_high = write_hit(wr_access, paddr, wdt_pkg::ADDR_COUNT_HIGH);
    assign wr_offset = write_hit(wr_access, paddr, wdt_pkg::ADDR_OFFSET);
    assign wr_match = write_hit(wr_access, paddr, wdt_pkg::ADDR_MATCH);
    assign wr_status = write_hit(wr_access, paddr, wdt_pkg::ADDR_STATUS);

    assign watchdog_active = watchdog_enable_bit | watchdog_lock_bit;

    assign suspended = idle_suspend_bit & cpu_idle;

    array_clock_divider u_divider (
        .pclk(pclk),
        .presetn(presetn),
        .clear(soft_clear),
        .select(array_clock_select),
        .timer0_overflow(timer0_overflow),
        .eci_pin(eci_pin),
        .extclk_pin(extclk_pin),
        .tick(raw_tick)
    );

    // Counter also runs for the watchdog, so no run bit is needed after reset
    assign count_enable = (counter_run | watchdog_active) & ~suspended;
    assign step = raw_tick & count_enable & ~soft_clear;
    assign low_wrap = step & (array_count_low == 8'hFF);
    assign count_full = low_wrap & (array_count_high == 8'hFF);

    // overflow while high byte matches
    // Compare uses the high byte before the wrap increments it
    assign high_matches = (array_count_high == watchdog_match_reg);
    assign timeout_hit = watchdog_active & low_wrap & high_matches;

    assign force_write = wr_control & wbyte[wdt_pkg::CTRL_CAPTURE2_BIT];
    assign force_hit = watchdog_active & force_write;

    assign fire = (timeout_hit | force_hit) & ~soft_clear;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_clear <= 1'b0;
        end else begin
            soft_clear <= fire;
        end
    end

    // Registered so the system reset request cannot glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reset <= 1'b0;
        end else begin
            watchdog_reset <= fire;
        end
    end

    // Cause flag survives the watchdog clear; write 1 clears, firing wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fired_flag <= 1'b0;
        end else if (fire) begin
            fired_flag <= 1'b1;
        end else if (wr_status & wbyte[wdt_pkg::STAT_FIRED_BIT]) begin
            fired_flag <= 1'b0;
        end
    end

    // Counter low byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            array_count_low <= wdt_pkg::BYTE_RESET;
        end else if (soft_clear) begin
            array_count_low <= wdt_pkg::BYTE_RESET;
        end else if (wr_low) begin
            array_count_low <= wbyte;
        end else if (step) begin
            array_count_low <= array_count_low + 8'h01;
        end
    end

    // Counter high byte advances on low wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            array_count_high <= wdt_pkg::BYTE_RESET;
        end else if (soft_clear) begin
            array_count_high <= wdt_pkg::BYTE_RESET;
        end else if (wr_high) begin
            array_count_high <= wbyte;
        end else if (low_wrap) begin
            array_count_high <= array_count_high + 8'h01;
        end
    end

    // Offset register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_offset_reg <= wdt_pkg::BYTE_RESET;
        end else if (soft_clear) begin
            watchdog_offset_reg <= wdt_pkg::BYTE_RESET;
        end else if (wr_offset) begin
            watchdog_offset_reg <= wbyte;
        end
    end

    // Match register: write data ignored, loaded from the live count.
    // High plus offset gives 256*offset + 256 - low counter clocks,
    // since the compare uses the high byte before its increment.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_match_reg <= wdt_pkg::BYTE_RESET;
        end else if (soft_clear) begin
            watchdog_match_reg <= wdt_pkg::BYTE_RESET;
        end else if (wr_match) begin
            watchdog_match_reg <= restart_point(array_count_high, watchdog_offset_reg);
        end
    end

    // Control register run bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_run <= wdt_pkg::RUN_RESET;
        end else if (soft_clear) begin
            counter_run <= wdt_pkg::RUN_RESET;
        end else if (wr_control) begin
            counter_run <= wbyte[wdt_pkg::CTRL_RUN_BIT];
        end
    end

    // Overflow flag on the 16-bit wrap; set wins over a clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag <= 1'b0;
        end else if (soft_clear) begin
            overflow_flag <= 1'b0;
        end else if (count_full) begin
            overflow_flag <= 1'b1;
        end else if (wr_control & ~wbyte[wdt_pkg::CTRL_OVERFLOW_BIT]) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_lock_bit <= wdt_pkg::LOCK_RESET;
        end else if (soft_clear) begin
            watchdog_lock_bit <= wdt_pkg::LOCK_RESET;
        end else if (wr_mode & wbyte[wdt_pkg::MODE_LOCK_BIT]) begin
            watchdog_lock_bit <= 1'b1;
        end
    end

    // Enable bit; a set lock makes writes to it ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_enable_bit <= wdt_pkg::ENABLE_RESET;
        end else if (soft_clear) begin
            watchdog_enable_bit <= wdt_pkg::ENABLE_RESET;
        end else if (wr_mode & ~watchdog_lock_bit) begin
            watchdog_enable_bit <= wbyte[wdt_pkg::MODE_ENABLE_BIT];
        end
    end

    assign mode_open = wr_mode & ~watchdog_active;

    // Counter clock source select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            array_clock_select <= wdt_pkg::SEL_RESET;
        end else if (soft_clear) begin
            array_clock_select <= wdt_pkg::SEL_RESET;
        end else if (mode_open) begin
            array_clock_select <= wbyte[wdt_pkg::MODE_SEL_LSB +: wdt_pkg::SEL_W];
        end
    end

    // Idle suspend select; with it set an idle CPU halts the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_suspend_bit <= wdt_pkg::IDLE_RESET;
        end else if (soft_clear) begin
            idle_suspend_bit <= wdt_pkg::IDLE_RESET;
        end else if (mode_open) begin
            idle_suspend_bit <= wbyte[wdt_pkg::MODE_IDLE_BIT];
        end
    end

    // Control image; the forcing bit always reads 0
    always_comb begin
        control_image = 8'h00;
        control_image[wdt_pkg::CTRL_OVERFLOW_BIT] = overflow_flag;
        control_image[wdt_pkg::CTRL_RUN_BIT] = counter_run;
    end

    // Mode image
    always_comb begin
        mode_image = 8'h00;
        mode_image[wdt_pkg::MODE_IDLE_BIT] = idle_suspend_bit;
        mode_image[wdt_pkg::MODE_ENABLE_BIT] = watchdog_enable_bit;
        mode_image[wdt_pkg::MODE_LOCK_BIT] = watchdog_lock_bit;
        mode_image[wdt_pkg::MODE_SEL_LSB +: wdt_pkg::SEL_W] = array_clock_select;
    end

    // Status image; the fired flag outlives the watchdog clear
    always_comb begin
        status_image = 8'h00;
        status_image[wdt_pkg::STAT_ACTIVE_BIT] = watchdog_active;
        status_image[wdt_pkg::STAT_FIRED_BIT] = fired_flag;
        status_image[wdt_pkg::STAT_SUSPENDED_BIT] = suspended;
    end

    // Read mux
    always_comb begin
        next_read = 8'h00;
        unique case (paddr)
            wdt_pkg::ADDR_CONTROL: next_read = control_image;
            wdt_pkg::ADDR_MODE: next_read = mode_image;
            wdt_pkg::ADDR_COUNT_LOW: next_read = array_count_low;
            wdt_pkg::ADDR_COUNT_HIGH: next_read = array_count_high;
            wdt_pkg::ADDR_OFFSET: next_read = watchdog_offset_reg;
            wdt_pkg::ADDR_MATCH: next_read = watchdog_match_reg;
            wdt_pkg::ADDR_STATUS: next_read = status_image;
            default: next_read = 8'h00;
        endcase
    end

    // Sampled in setup; a count may move during the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, next_read};
        end
    end

endmodule : counter_array_watchdog

/* hw/wdt_pkg.sv */
// Purpose: Shared constants for the counter array watchdog
// Assumes: APB byte addresses, 32-bit data, 8-bit registers in low bits
package wdt_pkg;

    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_MATCH = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;

    // Control register fields
    localparam int CTRL_OVERFLOW_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_CAPTURE2_BIT = 2;

    // Mode register fields
    localparam int MODE_IDLE_BIT = 7;
    localparam int MODE_ENABLE_BIT = 6;
    localparam int MODE_LOCK_BIT = 5;
    localparam int MODE_SEL_LSB = 1;
    localparam int SEL_W = 3;

    // Status register fields
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_FIRED_BIT = 1;
    localparam int STAT_SUSPENDED_BIT = 2;

    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic RUN_RESET = 1'b0;
    localparam logic ENABLE_RESET = 1'b1;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic IDLE_RESET = 1'b0;

    typedef enum logic [SEL_W-1:0] {
        SEL_SYS_DIV12,
        SEL_SYS_DIV4,
        SEL_TIMER0,
        SEL_EXT_EDGE,
        SEL_SYSTEM,
        SEL_EXTCLK_DIV8
    } clock_sel_t;

    localparam clock_sel_t SEL_RESET = SEL_SYS_DIV12;

    localparam int DIV12_COUNT = 12;
    localparam int DIV4_COUNT = 4;
    localparam int EXT_DIV_COUNT = 8;

endpackage : wdt_pkg

/* tb/counter_array_watchdog_bench.sv */
// Purpose: Self-checking bench for the watchdog block
// Assumes: Source 4 counts every pclk; pins of other sources tied low
// Notes: Timeouts allow a few cycles of bus and divider slack
`timescale 1ns/1ps
module counter_array_watchdog_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic cpu_idle = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic watchdog_reset;
    logic watchdog_active;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    int fires = 0;
    int fire_cyc = 0;
    int t0, at, f0, off, low;
    logic [31:0] seed = 32'h0000_3662;
    logic [32:0] exp_q[$];
    counter_array_watchdog dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
        .timer0_overflow(1'b0), .eci_pin(1'b0), .extclk_pin(1'b0),
        .watchdog_reset(watchdog_reset), .watchdog_active(watchdog_active));
    always #5 pclk = ~pclk;
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task close_out();
        if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task check_val(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task check_near(input int got, input int exp, input int tol);
        n_checks++;
        if (got < exp - tol || got > exp + tol) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_near
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (watchdog_reset === 1'b1) begin
            fires <= fires + 1;
            fire_cyc <= cyc;
        end
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end
    // Read results taken at the access edge, oldest note first
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (exp_q.size() == 0) check_val({pslverr, prdata}, 33'h1);
            else check_val({pslverr, prdata}, exp_q.pop_front());
        end
    end
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e, input logic err = 1'b0);
        exp_q.push_back({err, 24'h0, e});
        apb(1'b0, a, 8'h00);
    endtask : rd
    task wait_fire();
        int k;
        k = 0;
        f0 = fires;
        while (fires == f0 && k < 5000) begin
            @(posedge pclk);
            k++;
        end
        if (k == 5000) mismatches++;
        at = fire_cyc;
    endtask : wait_fire
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(wdt_pkg::ADDR_COUNT_LOW, 8'h00);
        rd(wdt_pkg::ADDR_MODE, 8'h40);
        rd(wdt_pkg::ADDR_OFFSET, 8'h00);
        rd(8'h1C, 8'h00, 1'b1);
        // setup order, random offset and start count
        for (int i = 0; i < 3; i++) begin
            off = rnd() % 3;
            low = rnd() & 32'h7F;
            wr(wdt_pkg::ADDR_MODE, 8'h00);
            wr(wdt_pkg::ADDR_MODE, 8'h08);
            wr(wdt_pkg::ADDR_COUNT_LOW, low[7:0]);
            wr(wdt_pkg::ADDR_OFFSET, off[7:0]);
            wr(wdt_pkg::ADDR_MODE, 8'h48);
            t0 = cyc;
            wr(wdt_pkg::ADDR_MATCH, 8'(rnd()));
            wait_fire();
            check_near(at - t0, 256 * off + 256 - low, 6);
            rd(wdt_pkg::ADDR_MODE, 8'h40);
            rd(wdt_pkg::ADDR_OFFSET, 8'h00);
        end
        wr(wdt_pkg::ADDR_MODE, 8'h00);
        wr(wdt_pkg::ADDR_MODE, 8'h88);
        wr(wdt_pkg::ADDR_OFFSET, 8'hFF);
        wr(wdt_pkg::ADDR_MODE, 8'hC8);
        wr(wdt_pkg::ADDR_MATCH, 8'h00);
        cpu_idle <= 1'b1;
        wr(wdt_pkg::ADDR_COUNT_LOW, 8'h55);
        repeat (20) @(posedge pclk);
        rd(wdt_pkg::ADDR_COUNT_LOW, 8'h55);
        cpu_idle <= 1'b0;
        wr(wdt_pkg::ADDR_MODE, 8'h40);
        rd(wdt_pkg::ADDR_MODE, 8'hC8);
        wr(wdt_pkg::ADDR_CONTROL, 8'h04);
        wait_fire();
        rd(wdt_pkg::ADDR_MODE, 8'h40);
        wr(wdt_pkg::ADDR_MODE, 8'h60);
        wr(wdt_pkg::ADDR_MODE, 8'h00);
        @(posedge pclk);
        check_val(watchdog_active, 33'h1);
        rd(wdt_pkg::ADDR_MODE, 8'h60);
        wr(wdt_pkg::ADDR_CONTROL, 8'h04);
        wait_fire();
        rd(wdt_pkg::ADDR_MODE, 8'h40);
        wr(wdt_pkg::ADDR_MODE, 8'h00);
        @(posedge pclk);
        check_val(watchdog_active, 33'h0);
        f0 = fires;
        wr(wdt_pkg::ADDR_CONTROL, 8'h04);
        repeat (5) @(posedge pclk);
        check_val(33'(fires), 33'(f0));
        wr(wdt_pkg::ADDR_MODE, 8'h40);
        wr(wdt_pkg::ADDR_CONTROL, 8'h04);
        wait_fire();
        t0 = at;
        wait_fire();
        check_near(at - t0, 3072, 24);
        close_out();
    end
endmodule : counter_array_watchdog_bench
bind counter_array_watchdog counter_array_watchdog_monitor mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
    .timer0_overflow(timer0_overflow), .eci_pin(eci_pin), .extclk_pin(extclk_pin),
    .watchdog_reset(watchdog_reset), .watchdog_active(watchdog_active));

/* tb/counter_array_watchdog_monitor.sv */
// Purpose: Port-level timing checks of the watchdog block
// Assumes: APB writes land at the access edge; clear cycle drops all writes but a status write
// Notes: Lock and offset are mirrored from bus writes
`timescale 1ns/1ps
module counter_array_watchdog_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic eci_pin,
    input wire logic extclk_pin,
    input wire logic watchdog_reset,
    input wire logic watchdog_active
);
    logic wr_ok;
    logic mode_wr;
    logic locked;
    logic [7:0] off_q;
    assign wr_ok = psel && penable && pwrite && !watchdog_reset;
    assign mode_wr = wr_ok && paddr == wdt_pkg::ADDR_MODE;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked <= 1'b0;
        end else if (watchdog_reset) begin
            locked <= 1'b0;
        end else if (mode_wr && pwdata[wdt_pkg::MODE_LOCK_BIT]) begin
            locked <= 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_q <= 8'h00;
        end else if (watchdog_reset) begin
            off_q <= 8'h00;
        end else if (wr_ok && paddr == wdt_pkg::ADDR_OFFSET) begin
            off_q <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_force;
        wr_ok && paddr == wdt_pkg::ADDR_CONTROL && pwdata[wdt_pkg::CTRL_CAPTURE2_BIT]
            && watchdog_active |=> watchdog_reset;
    endproperty
    a_force: assert property (p_force) else $error("forced reset missing");
    property p_rst_on;
        $rose(presetn) |-> watchdog_active;
    endproperty
    a_rst_on: assert property (p_rst_on) else $error("not enabled after reset");
    property p_clear_on;
        watchdog_reset |=> watchdog_active;
    endproperty
    a_clear_on: assert property (p_clear_on) else $error("not enabled after fire");
    property p_lock;
        mode_wr && pwdata[wdt_pkg::MODE_LOCK_BIT] |=> watchdog_active [*8];
    endproperty
    a_lock: assert property (p_lock) else $error("lock did not hold");
    property p_off;
        mode_wr && pwdata[6:5] == 2'b00 && !locked |=> !watchdog_active;
    endproperty
    a_off: assert property (p_off) else $error("disable ignored");
    property p_on;
        mode_wr && pwdata[6:5] != 2'b00 |=> watchdog_active;
    endproperty
    a_on: assert property (p_on) else $error("enable ignored");
    property p_restart;
        wr_ok && paddr == wdt_pkg::ADDR_MATCH && off_q != 8'h00 |=> !watchdog_reset [*8];
    endproperty
    a_restart: assert property (p_restart) else $error("fired right after restart");
    property p_pulse;
        watchdog_reset |=> !watchdog_reset;
    endproperty
    a_pulse: assert property (p_pulse) else $error("fire not a single pulse");
endmodule : counter_array_watchdog_monitor
